// ---- src/scdc_pkg.sv ----
/*
  scdc_pkg: register map, field layouts, reset values and shared
  helpers of the lane configuration block.
  assumes: used by every file of the block, never imported.
*/
package scdc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CLK = 8'h00;
  localparam logic [7:0] ADDR_DES = 8'h04;
  localparam logic [7:0] ADDR_IB = 8'h08;
  localparam logic [7:0] ADDR_OB = 8'h0C;
  localparam logic [7:0] ADDR_OB1 = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // writable bits per register; the rest read as zero
  localparam logic [31:0] MASK_CLK = 32'h0000_007F;
  localparam logic [31:0] MASK_DES = 32'h0000_03FF;
  localparam logic [31:0] MASK_IB = 32'h0000_00FF;
  localparam logic [31:0] MASK_OB = 32'h03FF_FFFF;
  localparam logic [31:0] MASK_OB1 = 32'h0000_003F;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [24:0] rsvd;
    logic txPhaseAlignEn;
    logic quarterRateSel;
    logic halfRateSel;
    logic sharedClockSquelchEn;
    logic laneClockSquelchEn;
    logic sharedClockOutSelect;
    logic laneClockOutSelect;
  } scdc_clk_s;

  typedef struct packed {
    logic [21:0] rsvd;
    logic deadlockGuardCfg;
    logic [2:0] proportionalBwSetting;
    logic [2:0] integratorTimeConst;
    logic [2:0] integratorLimitCfg;
  } scdc_des_s;

  typedef struct packed {
    logic [23:0] rsvd;
    logic rxOffsetCompDcEn;
    logic rxOffsetCompAcEn;
    logic rxLowrateFxEn;
    logic [3:0] levelDetectThreshold;
    logic rxCmTermEn;
  } scdc_ib_s;

  typedef struct packed {
    logic [5:0] rsvd;
    logic [3:0] txSlewFine;
    logic [1:0] txSlewCoarse;
    logic txSkewAdjust;
    logic txLowSupplyMode;
    logic txIdleEn;
    logic txCenterPolarity;
    logic [4:0] txPostcursor2Coef;
    logic [5:0] txPostcursor1Coef;
    logic [4:0] txPrecursorCoef;
  } scdc_ob_s;

  // tap set handed to the analog driver
  typedef struct packed {
    logic signed [6:0] pre;
    logic signed [6:0] post1;
    logic signed [6:0] post2;
    logic [5:0] centerMag;
    logic centerInv;
    logic [6:0] ampK;
    logic idle;
  } scdc_taps_s;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam scdc_clk_s CLK_RESET = 32'h0000_0000;
  localparam scdc_des_s DES_RESET = 32'h0000_016B;
  localparam scdc_ib_s IB_RESET = 32'h0000_00D0;
  localparam scdc_ob_s OB_RESET = 32'h0001_0000;
  localparam logic [5:0] OB1_RESET = 6'h00;

  // ---------------------------------------------------------------
  // loop and tap constants
  // ---------------------------------------------------------------
  localparam logic [6:0] AMP_OFFSET = 7'h40;
  localparam logic [6:0] CENTER_BASE = 7'h40;
  localparam logic [5:0] CENTER_MAX = 6'h3F;
  localparam logic [5:0] GUARD_PERIOD = 6'h3F;
  localparam logic [15:0] PPM_TOP_X16 = 16'h7A12;
  localparam logic [2:0] BW_FIRST_HALF = 3'h3;
  localparam logic [2:0] BW_FIRST_QUARTER = 3'h2;

  // offset limit in ppm, 16x scaled so halving rounds like the table
  function automatic logic [10:0] ppmLimit(input logic [2:0] bw, input logic qr);
    logic [2:0] first;
    logic [15:0] scaled;
    first = qr ? BW_FIRST_QUARTER : BW_FIRST_HALF;
    scaled = (PPM_TOP_X16 >> (bw - first)) + 16'h0008;
    ppmLimit = (bw < first) ? 11'h000 : scaled[14:4];
  endfunction

  function automatic logic signed [6:0] smToSigned(input logic [5:0] mag, input logic neg);
    smToSigned = neg ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction

endpackage

// ---- src/scdc_pi_loop.sv ----
/*
  scdc_pi_loop: proportional-integral phase regulator of the cdr,
  with integrator limit, time constant and deadlock offset.
  assumes: early/late decisions arrive on core_clk.
*/
`timescale 1ns/10ps
module scdc_pi_loop (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration
  input wire scdc_pkg::scdc_des_s desCfg,
  // phase detector
  input wire logic pdEarly,
  input wire logic pdLate,
  // loop state
  output logic [7:0] phaseCode,
  output logic signed [7:0] integ
);
  logic [7:0] gain;
  logic [7:0] limRaw;
  logic signed [7:0] limit;
  logic signed [9:0] thr;
  logic signed [9:0] subAcc;
  logic signed [9:0] next_subAcc;
  logic signed [1:0] err;
  logic signed [9:0] propTerm;
  logic [5:0] guardCnt;
  logic guardStep;
  logic signed [9:0] delta;

  // -----------------------------------------------------------------
  // gains
  // -----------------------------------------------------------------
  assign err = (pdLate & ~pdEarly) ? 2'sh1 : ((pdEarly & ~pdLate) ? 2'sh3 : 2'sh0);
  assign gain = 8'h01 << (3'h7 - desCfg.proportionalBwSetting);
  assign limRaw = 8'h01 << desCfg.integratorLimitCfg;
  // limit capped below proportional gain
  assign limit = $signed((limRaw < gain) ? limRaw : gain - 8'h01);
  // smaller setting, smaller threshold, faster integrator
  assign thr = 10'sh001 <<< desCfg.integratorTimeConst;
  assign next_subAcc = subAcc + 10'(err);
  assign propTerm = (err == 2'sh1) ? $signed({2'h0, gain}) :
                    ((err == 2'sh3) ? -$signed({2'h0, gain}) : 10'sh000);
  assign guardStep = desCfg.deadlockGuardCfg & (guardCnt == scdc_pkg::GUARD_PERIOD);
  assign delta = propTerm + 10'(integ) + $signed({9'h000, guardStep});

  // -----------------------------------------------------------------
  // integrator: dithers between two codes at lock
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      subAcc <= 10'sh000;
      integ <= 8'sh00;
    end
    // a lowered limit pulls the integrator back in at once
    else if ((integ > limit) || (integ < -limit))
    begin
      subAcc <= 10'sh000;
      integ <= (integ > limit) ? limit : -limit;
    end
    else if (next_subAcc >= thr)
    begin
      subAcc <= 10'sh000;
      if (integ < limit)
        integ <= integ + 8'sh01;
    end
    else if (next_subAcc <= -thr)
    begin
      subAcc <= 10'sh000;
      if (integ > -limit)
        integ <= integ - 8'sh01;
    end
    else
      subAcc <= next_subAcc;
  end

  // small fixed drift pulls sampling off the 180 degree point
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      guardCnt <= 6'h00;
    else if (desCfg.deadlockGuardCfg)
      guardCnt <= guardCnt + 6'h01;
    else
      guardCnt <= 6'h00;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      phaseCode <= 8'h00;
    else
      phaseCode <= phaseCode + delta[7:0];
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_PI_WEAKER: assert property ($signed({1'b0, gain}) > 9'(limit))
    else $error("integrator limit not below proportional gain");
  AST_PI_TIMECONST: assert property ((next_subAcc >= thr) && (integ < limit)
    && (integ >= -limit) |=> integ == $past(integ) + 8'sh01)
    else $error("integrator missed its threshold step");
  AST_PI_GUARD: assert property (guardStep |=> !guardStep [*8])
    else $error("deadlock offset stepped too often");
  AST_PI_BOUND: assert property (1'b1 |=> (integ <= $past(limit)) && (integ >= -$past(limit)))
    else $error("integrator left its limits");

endmodule // scdc_pi_loop

// ---- src/scdc_tap_encoder.sv ----
/*
  scdc_tap_encoder: turns the driver coefficient fields into signed
  taps, the derived center tap and the amplitude coefficient.
  assumes: fields are static while traffic runs.
*/
`timescale 1ns/10ps
module scdc_tap_encoder (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // driver fields
  input wire scdc_pkg::scdc_ob_s obCfg,
  input wire logic [5:0] txAmplitudeLevel,
  // taps
  output scdc_pkg::scdc_taps_s taps
);
  logic [6:0] magSum;
  logic [6:0] centerRaw;

  // -----------------------------------------------------------------
  // center tap = 64 minus the other magnitudes
  // -----------------------------------------------------------------
  assign magSum = {3'h0, obCfg.txPrecursorCoef[3:0]} + {2'h0, obCfg.txPostcursor1Coef[4:0]} +
                  {3'h0, obCfg.txPostcursor2Coef[3:0]};
  assign centerRaw = scdc_pkg::CENTER_BASE - magSum;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      taps <= '0;
      taps.ampK <= scdc_pkg::AMP_OFFSET;
      taps.centerInv <= 1'b1;
    end
    else
    begin
      // idle zeroes every tap so the pair sits near quiet
      taps.idle <= obCfg.txIdleEn;
      taps.pre <= obCfg.txIdleEn ? 7'sh00 :
        scdc_pkg::smToSigned({2'h0, obCfg.txPrecursorCoef[3:0]}, obCfg.txPrecursorCoef[4]);
      taps.post1 <= obCfg.txIdleEn ? 7'sh00 :
        scdc_pkg::smToSigned({1'b0, obCfg.txPostcursor1Coef[4:0]}, obCfg.txPostcursor1Coef[5]);
      taps.post2 <= obCfg.txIdleEn ? 7'sh00 :
        scdc_pkg::smToSigned({2'h0, obCfg.txPostcursor2Coef[3:0]}, obCfg.txPostcursor2Coef[4]);
      // all-zero side taps would give 64, clipped to the 6-bit top
      if (obCfg.txIdleEn)
        taps.centerMag <= 6'h00;
      else if (centerRaw[6])
        taps.centerMag <= scdc_pkg::CENTER_MAX;
      else
        taps.centerMag <= centerRaw[5:0];
      taps.centerInv <= obCfg.txCenterPolarity;
      taps.ampK <= {1'b0, txAmplitudeLevel} + scdc_pkg::AMP_OFFSET;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_TAP_CENTER: assert property (!obCfg.txIdleEn && (magSum != 7'h00)
    |=> 7'(taps.centerMag) + $past(magSum) == scdc_pkg::CENTER_BASE)
    else $error("center tap does not complete 64");
  AST_TAP_AMP: assert property (taps.ampK[6])
    else $error("amplitude coefficient below 64");
  AST_TAP_RANGE: assert property ((taps.pre <= 7'sh0F) && (taps.pre >= -7'sh0F)
    && (taps.post1 <= 7'sh1F) && (taps.post1 >= -7'sh1F))
    else $error("tap outside sign-magnitude range");
  AST_TAP_IDLE: assert property (obCfg.txIdleEn |=> taps.idle && (taps.centerMag == 6'h00)
    && (taps.pre == 7'sh00))
    else $error("idle left a tap driving");

endmodule // scdc_tap_encoder

// ---- src/scdc_lane_top.sv ----
/*
  scdc_lane_top: configuration registers and digital control of one
  serial lane: recovered clock routing and squelch, cdr regulator,
  serializer phase align, input buffer and driver controls.
  assumes: register master, pcs and phase detector on core_clk; the
  recovered clock arrives from the analog cdr without a relation to it.
*/
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
// What this block does
// - recovered clock routes separately to the lane output and the shared output.
// - with squelch enabled, a clock output stops while pcs sees no data.
// - phase loop is proportional-integral, integrator always weaker than proportional path.
// - lower time constant setting makes the integrator respond faster.
// - integrator cancels static offset, dithering between two neighbouring codes.
// - offset limits halve per bandwidth step from 1953 ppm, per rate.
// - deadlock guard adds a small steady drift to the phase loop.
// - serializer phase aligns to the cdr phase when align is enabled.
// - supply mode resets to 1.2 V; software never selects 1.0 V wrongly.
// - pre-cursor and second post-cursor are 5-bit sign-magnitude, -15 to 15.
// - center tap is 64 minus other magnitudes (63 when all are zero), with its own polarity.
// - center polarity 0 is non-inverting, 1 inverting; normally set 1.
// - amplitude field plus 64 forms the amplitude coefficient, 64 to 127.
// - idle mode drives the outputs near quiet instead of data.
// - skew adjust acts only in 1 Gbps sgmii mode.
module scdc_lane_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // recovered clock and pcs status
  input wire logic recClkIn,
  input wire logic pcsNoData,
  output logic recClkLaneOut,
  output logic recClkSharedOut,
  output logic recClkSharedOe,
  // phase detector and rotators
  input wire logic pdEarly,
  input wire logic pdLate,
  output logic [7:0] cdrPhase,
  output logic [7:0] serPhase,
  // input buffer controls
  output scdc_pkg::scdc_ib_s ibCtl,
  // output buffer controls
  output scdc_pkg::scdc_taps_s obTaps,
  output logic txLowSupplyMode,
  output logic txSkewAdjust,
  output logic [1:0] txSlewCoarse,
  output logic [3:0] txSlewFine
);
  scdc_pkg::scdc_clk_s clkCfg;
  scdc_pkg::scdc_des_s desCfg;
  scdc_pkg::scdc_ob_s obCfg;
  logic [5:0] txAmplitudeLevel;
  logic [31:0] next_regRdata;
  logic recSync1;
  logic recSync2;
  logic laneSquelch;
  logic sharedSquelch;
  logic signed [7:0] integ;
  logic [10:0] offsetLimitPpm;

  // -----------------------------------------------------------------
  // register writes
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      clkCfg <= scdc_pkg::CLK_RESET;
    else if (regWr && (regAddr == scdc_pkg::ADDR_CLK))
      clkCfg <= regWdata & scdc_pkg::MASK_CLK;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      desCfg <= scdc_pkg::DES_RESET;
    else if (regWr && (regAddr == scdc_pkg::ADDR_DES))
      desCfg <= regWdata & scdc_pkg::MASK_DES;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ibCtl <= scdc_pkg::IB_RESET;
    else if (regWr && (regAddr == scdc_pkg::ADDR_IB))
      ibCtl <= regWdata & scdc_pkg::MASK_IB;
  end

  // supply mode bit resets low, selecting 1.2 V
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      obCfg <= scdc_pkg::OB_RESET;
    else if (regWr && (regAddr == scdc_pkg::ADDR_OB))
      obCfg <= regWdata & scdc_pkg::MASK_OB;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      txAmplitudeLevel <= scdc_pkg::OB1_RESET;
    else if (regWr && (regAddr == scdc_pkg::ADDR_OB1))
      txAmplitudeLevel <= regWdata[5:0];
  end

  // -----------------------------------------------------------------
  // register reads: data only in the cycle after the strobe
  // -----------------------------------------------------------------
  // offset capability shown for the selected rate
  assign offsetLimitPpm = scdc_pkg::ppmLimit(desCfg.proportionalBwSetting,
                                             clkCfg.quarterRateSel);

  always_comb
  begin
    if (regAddr == scdc_pkg::ADDR_CLK)
      next_regRdata = clkCfg;
    else if (regAddr == scdc_pkg::ADDR_DES)
      next_regRdata = desCfg;
    else if (regAddr == scdc_pkg::ADDR_IB)
      next_regRdata = ibCtl;
    else if (regAddr == scdc_pkg::ADDR_OB)
      next_regRdata = obCfg;
    else if (regAddr == scdc_pkg::ADDR_OB1)
      next_regRdata = {26'h0000000, txAmplitudeLevel};
    else if (regAddr == scdc_pkg::ADDR_STAT)
      next_regRdata = {5'h00, sharedSquelch, laneSquelch, offsetLimitPpm,
                       obTaps.centerMag, integ};
    else
      next_regRdata = scdc_pkg::RD_UNMAPPED;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      regRdata <= 32'h0000_0000;
    else if (regRd)
      regRdata <= next_regRdata;
    else
      regRdata <= 32'h0000_0000;
  end

  // -----------------------------------------------------------------
  // recovered clock routing
  // -----------------------------------------------------------------
  // sampled view of the recovered clock; true routing is a clock mux
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      recSync1 <= 1'b0;
      recSync2 <= 1'b0;
    end
    else
    begin
      recSync1 <= recClkIn;
      recSync2 <= recSync1;
    end
  end

  // squelch follows pcs loss of valid data
  assign laneSquelch = clkCfg.laneClockSquelchEn & pcsNoData;
  assign sharedSquelch = clkCfg.sharedClockSquelchEn & pcsNoData;

  // each output has its own select
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      recClkLaneOut <= 1'b0;
      recClkSharedOut <= 1'b0;
      recClkSharedOe <= 1'b0;
    end
    else
    begin
      recClkLaneOut <= recSync2 & clkCfg.laneClockOutSelect & ~laneSquelch;
      recClkSharedOut <= recSync2 & clkCfg.sharedClockOutSelect & ~sharedSquelch;
      // shared pin released when not selected; one lane only
      recClkSharedOe <= clkCfg.sharedClockOutSelect;
    end
  end

  // -----------------------------------------------------------------
  // cdr phase regulator
  // -----------------------------------------------------------------
  scdc_pi_loop u_pi (
    .core_clk(core_clk),
    .rst(rst),
    .desCfg(desCfg),
    .pdEarly(pdEarly),
    .pdLate(pdLate),
    .phaseCode(cdrPhase),
    .integ(integ)
  );

  // -----------------------------------------------------------------
  // serializer phase: free-runs unless aligned to the cdr phase
  // -----------------------------------------------------------------
  // facility loopback source is the recovered phase
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      serPhase <= 8'h00;
    else if (clkCfg.txPhaseAlignEn)
      serPhase <= cdrPhase;
    else
      serPhase <= serPhase + 8'h01;
  end

  // -----------------------------------------------------------------
  // output buffer
  // -----------------------------------------------------------------
  scdc_tap_encoder u_taps (
    .core_clk(core_clk),
    .rst(rst),
    .obCfg(obCfg),
    .txAmplitudeLevel(txAmplitudeLevel),
    .taps(obTaps)
  );

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      txLowSupplyMode <= 1'b0;
      txSkewAdjust <= 1'b0;
      txSlewCoarse <= 2'h0;
      txSlewFine <= 4'h0;
    end
    else
    begin
      txLowSupplyMode <= obCfg.txLowSupplyMode;
      // 1 Gbps sgmii is quarter rate; other modes mask skew
      txSkewAdjust <= obCfg.txSkewAdjust & clkCfg.quarterRateSel & ~clkCfg.halfRateSel;
      txSlewCoarse <= obCfg.txSlewCoarse;
      txSlewFine <= obCfg.txSlewFine;
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_LANE_ROUTE: assert property (!clkCfg.laneClockOutSelect
    |=> !recClkLaneOut)
    else $error("lane clock out driven while deselected");
  AST_SHARED_ROUTE: assert property (clkCfg.sharedClockOutSelect && !sharedSquelch
    && recSync2 |=> recClkSharedOut)
    else $error("shared clock out missing while selected");
  AST_SQUELCH: assert property (clkCfg.laneClockSquelchEn && pcsNoData
    |=> !recClkLaneOut)
    else $error("lane clock not squelched on lost data");
  AST_ALIGN: assert property (clkCfg.txPhaseAlignEn |=> serPhase == $past(cdrPhase))
    else $error("serializer phase not aligned to source");
  AST_SKEW: assert property (clkCfg.halfRateSel |=> !txSkewAdjust)
    else $error("skew adjust active outside 1 Gbps mode");
  AST_SUPPLY: assert property ($rose(txLowSupplyMode) |-> $past(obCfg.txLowSupplyMode))
    else $error("low supply mode without software request");
  AST_RD_ONCE: assert property (!regRd |=> regRdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  COV_LANE_CLK: cover property (clkCfg.laneClockOutSelect ##1 recClkLaneOut);
  COV_SQUELCH: cover property (laneSquelch ##1 !recClkLaneOut);
  COV_ALIGN: cover property (clkCfg.txPhaseAlignEn ##1 clkCfg.txPhaseAlignEn);
  COV_INTEG: cover property (integ != 8'sh00);

endmodule // scdc_lane_top

// ---- bench/scdc_far_side.sv ----
/*
  scdc_far_side: line-side and pcs model of the lane: recovered
  clock, pcs no-data status and phase detector decisions.
  assumes: noData is driven by the bench on core_clk.
*/
`timescale 1ns/10ps
module scdc_far_side (
  // control from bench
  input wire logic core_clk,
  input wire logic noData,
  // lane inputs
  output logic recClkIn,
  output logic pcsNoData,
  output logic pdEarly,
  output logic pdLate
);
  logic [1:0] pdCnt = 2'h0;
  // period unrelated to core_clk, so the lane must synchronise it
  initial
  begin
    recClkIn = 1'b0;
    forever #7.3 recClkIn = ~recClkIn;
  end
  always @(posedge core_clk)
  begin
    pdCnt <= pdCnt + 2'h1;
    pcsNoData <= noData;
  end
  // mostly late: a steady offset for the loop to chase
  assign pdEarly = (pdCnt == 2'h0);
  assign pdLate = (pdCnt != 2'h0);
endmodule // scdc_far_side

// ---- bench/tb_top.sv ----
/*
  tb_top: register-level tests of the lane configuration block.
  assumes: far side model drives the recovered clock and pcs status.
*/
`timescale 1ns/10ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic noData = 1'b1;
  logic [31:0] regRdata;
  logic [31:0] d;
  logic recClkIn, pcsNoData, pdEarly, pdLate, laneOut, sharedOut, sharedOe, lowSup;
  logic skew;
  logic [7:0] cdrPh, serPh, p;
  scdc_pkg::scdc_ib_s ibCtl;
  scdc_pkg::scdc_taps_s obTaps;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int seen;
  int lim [0:5] = '{1953, 977, 488, 244, 122, 61};
  always #2 core_clk = ~core_clk;
  scdc_far_side far (.core_clk(core_clk), .noData(noData), .recClkIn(recClkIn),
    .pcsNoData(pcsNoData), .pdEarly(pdEarly), .pdLate(pdLate));
  scdc_lane_top dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .recClkIn(recClkIn), .pcsNoData(pcsNoData), .recClkLaneOut(laneOut),
    .recClkSharedOut(sharedOut), .recClkSharedOe(sharedOe), .pdEarly(pdEarly),
    .pdLate(pdLate), .cdrPhase(cdrPh), .serPhase(serPh), .ibCtl(ibCtl), .obTaps(obTaps),
    .txLowSupplyMode(lowSup), .txSkewAdjust(skew), .txSlewCoarse(), .txSlewFine());
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    v = regRdata;
  endtask
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h0C, d);
    chk("ob reset", 36'h10000, 36'(d));
    chk("low supply", 36'h0, 36'(lowSup));
    rd(8'h20, d);
    chk("unmapped", 36'h0, 36'(d));
    wr(8'h08, 32'hFFFF_FF00);
    chk("ib ctl", 36'h0, 36'(ibCtl));
    wr(8'h08, 32'h0000_0021);
    chk("ib fx", 36'h21, 36'(ibCtl));
    $display("test reset done");
    wr(8'h0C, 32'h000114B3);
    chk("taps", scdc_pkg::scdc_taps_s'{7'h7D, 7'h7B, 7'h02, 6'h36, 1'b1, 7'h40, 1'b0},
      obTaps);
    wr(8'h0C, 32'h0000FFFF);
    wr(8'h10, 32'h0000003F);
    chk("taps max", scdc_pkg::scdc_taps_s'{7'h71, 7'h61, 7'h71, 6'h03, 1'b0, 7'h7F, 1'b0},
      obTaps);
    wr(8'h0C, 32'h000B14B3);
    chk("idle", 36'h1, 36'({obTaps.pre, obTaps.post1, obTaps.post2,
      obTaps.centerMag, obTaps.idle}));
    chk("skew full", 36'h0, 36'(skew));
    $display("test taps done");
    for (int b = 2; b < 8; b++)
    begin
      wr(8'h00, 32'h10);
      wr(8'h04, 32'(b * 64 + 43));
      rd(8'h14, d);
      chk("half limit", 36'((b > 2) ? lim[b - 3] : 0), 36'(d[24:14]));
      chk("skew half", 36'h0, 36'(skew));
      wr(8'h00, 32'h20);
      rd(8'h14, d);
      chk("quarter limit", 36'(lim[b - 2]), 36'(d[24:14]));
      chk("skew quarter", 36'h1, 36'(skew));
    end
    $display("test limits done");
    wr(8'h00, 32'h0F);
    seen = 0;
    repeat (40) @(negedge core_clk) seen += int'(laneOut | sharedOut);
    chk("squelched", 36'h0, 36'(seen));
    chk("shared oe", 36'h1, 36'(sharedOe));
    noData <= 1'b0;
    repeat (8) @(posedge core_clk);
    seen = 0;
    repeat (40) @(negedge core_clk) seen += int'(laneOut & sharedOut);
    chk("clock runs", 36'h1, 36'(seen > 5));
    wr(8'h00, 32'h01);
    seen = 0;
    repeat (40) @(negedge core_clk) seen += int'(sharedOut | sharedOe);
    chk("shared off", 36'h0, 36'(seen));
    $display("test clocks done");
    wr(8'h04, 32'h0000036B);
    wr(8'h00, 32'h40);
    @(negedge core_clk) p = cdrPh;
    @(negedge core_clk) chk("align", 36'(p), 36'(serPh));
    repeat (70) @(posedge core_clk);
    $display("test align done");
    finish_test();
  end
endmodule // tb_top
